// ### hdl/scfg_pkg.sv
// Purpose: Shared types and constants for the secure module command flow guard
// Assumes: One command per handshake, one answer per command
// Notes:   Opcodes and widths are local encodings
package scfg_pkg;

  // ****************************************
  // Command opcodes and status codes
  // ****************************************
  typedef enum logic [3:0] {
    SCFG_CMD_BEGIN   = 4'h1,
    SCFG_CMD_END     = 4'h2,
    SCFG_CMD_CREATE  = 4'h3,
    SCFG_CMD_MODIFY  = 4'h4,
    SCFG_CMD_VALMOD  = 4'h5,
    SCFG_CMD_DELETE  = 4'h6,
    SCFG_CMD_OPEN    = 4'h7,
    SCFG_CMD_VERIFY  = 4'h8,
    SCFG_CMD_DIRWR   = 4'h9,
    SCFG_CMD_SEAL    = 4'hA,
    SCFG_CMD_SEARCH  = 4'hB,
    SCFG_CMD_BUFWR   = 4'hC,
    SCFG_CMD_BUFRD   = 4'hD,
    SCFG_CMD_LIMRST  = 4'hE
  } scfg_cmd_e;

  localparam logic [3:0] SCFG_ST_OK       = 4'h0;
  localparam logic [3:0] SCFG_ST_STATE    = 4'h1;
  localparam logic [3:0] SCFG_ST_NOVERIFY = 4'h2;
  localparam logic [3:0] SCFG_ST_DENIED   = 4'h3;
  localparam logic [3:0] SCFG_ST_LIMIT    = 4'h4;
  localparam logic [3:0] SCFG_ST_BADCMD   = 4'h5;
  localparam logic [3:0] SCFG_ST_RANGE    = 4'h6;

  // ****************************************
  // Sizes, session states and reset values
  // ****************************************
  localparam int         SCFG_BUF_BYTES  = 1024;
  localparam logic [7:0] SCFG_MAX_XFER   = 8'hFF;
  localparam logic [1:0] SCFG_SESS_IDLE  = 2'h2;
  localparam logic [1:0] SCFG_SESS_OPEN  = 2'h3;
  localparam logic [7:0] SCFG_INST_RESET = 8'h00;
  localparam logic [15:0] SCFG_CNT_RESET = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    scfg_cmd_e   cmd;
    logic [7:0]  product;
    logic [15:0] value;
    logic [9:0]  offset;
    logic [7:0]  length;
    logic [7:0]  data;
    logic        permit;
    logic        paramOk;
  } scfg_req_s;

  typedef struct packed {
    logic [3:0]  status;
    logic        sealValid;
    logic        keyValid;
    logic        rwKey;
    logic [7:0]  instanceId;
    logic [63:0] diversifier;
    logic [7:0]  data;
  } scfg_rsp_s;

endpackage : scfg_pkg

// ### hdl/scfg_limit_counter.sv
// Purpose: Saturating usage counter checked against a limit
// Assumes: Limit is stable while commands run
// Notes:   Cleared only by the owner's verified reset pulse
`timescale 1ns/1ns
`default_nettype none
module scfg_limit_counter #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] limit,
  input  wire logic [W-1:0] amount,
  input  wire logic         consume,
  input  wire logic         clear,
  output logic              reached,
  output logic [W-1:0]      used
);
  import scfg_pkg::*;

  wire logic [W:0] sum = {1'b0, used} + {1'b0, amount};

  assign reached = (used >= limit);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      used <= SCFG_CNT_RESET[W-1:0];
    end else if (clear) begin
      used <= SCFG_CNT_RESET[W-1:0];
    end else if (consume) begin
      used <= sum[W] ? {W{1'b1}} : sum[W-1:0];
    end
  end
endmodule // scfg_limit_counter
`default_nettype wire

// ### hdl/scfg_flow_guard.sv
// Purpose: Command sequencing and permission guard of the secure access module
// Assumes: Table lookups and parameter checks arrive as flags with each request
// Notes:   One answer per request, accepted or refused, one cycle after it
//
// Operation
// - Answers only follow a command; nothing is sent unprompted after reset.
// - Product commands accepted only in session state 3, entered by begin.
// - Create seals a new product only when the tables permit it.
// - Create generates an instance identifier placed in the product data.
// - Product seals diversified by media identifier with shell reference number.
// - Create, modify, value-modify, delete seal only when the tables authorise.
// - Open returns the read-only access keys for the product.
// - Read/write granted only for products verified in this session, except create.
// - Permitted create, modify, value-modify and delete return read/write passkeys.
// - Create checks the creation-count limit before sealing.
// - Value-modify checks the aggregate value limit before sealing.
// - A reached limit stops sealing for the command it governs.
// - Limits reset only on an accepted limit-reset command with a verified parameter from the back office.
// - End clears key stores and buffers; then only begin, seal or search.
// - Transaction seal accepted in session state 2 or 3.
// - Buffer write and read move one byte, with a length of up to 255 checked against the 1024-byte buffer.
`timescale 1ns/1ns
`default_nettype none
module scfg_flow_guard #(
  parameter int          CNT_W     = 16,
  parameter logic [15:0] CREATE_LIM = 16'h0010,
  parameter logic [15:0] VALUE_LIM  = 16'h1000
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                reqValid,
  input  wire scfg_pkg::scfg_req_s req,
  input  wire logic [31:0]         mediaId,
  input  wire logic [31:0]         shellRef,
  output logic                     rspValid,
  output scfg_pkg::scfg_rsp_s      rsp,
  output logic [1:0]               sessionState,
  output logic                     dirDirty
);
  import scfg_pkg::*;

  // ****************************************
  // Request decode
  // ****************************************
  logic [7:0]  buffer [SCFG_BUF_BYTES];
  logic [7:0]  verifiedProduct;
  logic        verifiedValid;
  logic [7:0]  instanceCtr;
  logic [SCFG_BUF_BYTES-1:0] bufValid;
  logic        createReached;
  logic        valueReached;

  wire logic inSession  = (sessionState == SCFG_SESS_OPEN);
  wire logic isCreate   = (req.cmd == SCFG_CMD_CREATE);
  wire logic isValMod   = (req.cmd == SCFG_CMD_VALMOD);
  wire logic isProdRw   = isCreate || isValMod || (req.cmd == SCFG_CMD_MODIFY) ||
                          (req.cmd == SCFG_CMD_DELETE);
  wire logic isProduct  = isProdRw || (req.cmd == SCFG_CMD_OPEN) || (req.cmd == SCFG_CMD_VERIFY) ||
                          (req.cmd == SCFG_CMD_DIRWR);
  wire logic isBuffer   = (req.cmd == SCFG_CMD_BUFWR) || (req.cmd == SCFG_CMD_BUFRD);
  wire logic knownCmd   = isProduct || isBuffer || (req.cmd == SCFG_CMD_BEGIN) ||
                          (req.cmd == SCFG_CMD_END) || (req.cmd == SCFG_CMD_SEAL) ||
                          (req.cmd == SCFG_CMD_SEARCH) || (req.cmd == SCFG_CMD_LIMRST);
  wire logic sealState  = (sessionState == SCFG_SESS_IDLE) || inSession;
  wire logic verifiedOk = verifiedValid && (verifiedProduct == req.product);
  wire logic [10:0] bufEnd = {1'b0, req.offset} + {3'b000, req.length};
  wire logic bufRangeOk = (req.length != 8'h00) && (req.length <= SCFG_MAX_XFER) &&
                          (bufEnd <= 11'(SCFG_BUF_BYTES));
  // Bytes never written in this session read back as zero
  wire logic [7:0] bufByte = bufValid[req.offset] ? buffer[req.offset] : 8'h00;

  // Error priority: unknown, state, verification, table, limit, buffer range
  wire logic stateBad   = (isProduct && !inSession) ||
                          ((req.cmd == SCFG_CMD_SEAL) && !sealState) ||
                          ((req.cmd == SCFG_CMD_END) && !inSession) ||
                          ((isBuffer || (req.cmd == SCFG_CMD_LIMRST)) && !inSession);
  wire logic verifyBad  = isProdRw && !isCreate && !verifiedOk;
  wire logic deniedBad  = (isProdRw || (req.cmd == SCFG_CMD_OPEN) ||
                           (req.cmd == SCFG_CMD_LIMRST)) &&
                          !(req.permit && req.paramOk);
  wire logic limitBad   = (isCreate && createReached) ||
                          (isValMod && valueReached);
  wire logic rangeBad   = isBuffer && !bufRangeOk;

  wire logic [3:0] status = !knownCmd  ? SCFG_ST_BADCMD   :
                            stateBad   ? SCFG_ST_STATE    :
                            verifyBad  ? SCFG_ST_NOVERIFY :
                            deniedBad  ? SCFG_ST_DENIED   :
                            limitBad   ? SCFG_ST_LIMIT    :
                            rangeBad   ? SCFG_ST_RANGE    : SCFG_ST_OK;
  wire logic accept     = reqValid && (status == SCFG_ST_OK);
  wire logic grantRw    = accept && isProdRw;
  wire logic grantRo    = accept && (req.cmd == SCFG_CMD_OPEN);
  wire logic doBegin    = accept && (req.cmd == SCFG_CMD_BEGIN);
  wire logic doEnd      = accept && (req.cmd == SCFG_CMD_END);
  wire logic limClear   = accept && (req.cmd == SCFG_CMD_LIMRST);
  wire logic [63:0] diversify = {mediaId, shellRef};

  // ****************************************
  // Limit counters
  // ****************************************
  scfg_limit_counter #(.W(CNT_W)) u_createLimit (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .limit   (CREATE_LIM[CNT_W-1:0]),
    .amount  ({{(CNT_W-1){1'b0}}, 1'b1}),
    .consume (accept && isCreate),
    .clear   (limClear),
    .reached (createReached),
    .used    ()
  );

  scfg_limit_counter #(.W(CNT_W)) u_valueLimit (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .limit   (VALUE_LIM[CNT_W-1:0]),
    .amount  (req.value[CNT_W-1:0]),
    .consume (accept && isValMod),
    .clear   (limClear),
    .reached (valueReached),
    .used    ()
  );

  // ****************************************
  // Session state and answer
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sessionState    <= SCFG_SESS_IDLE;
      verifiedValid   <= 1'b0;
      verifiedProduct <= 8'h00;
      instanceCtr     <= SCFG_INST_RESET;
      dirDirty        <= 1'b0;
      rspValid        <= 1'b0;
      rsp             <= '0;
    end else begin
      rspValid <= reqValid;
      if (reqValid) begin
        rsp.status      <= status;
        rsp.sealValid   <= accept && (isProdRw || (req.cmd == SCFG_CMD_SEAL) ||
                           (req.cmd == SCFG_CMD_DIRWR));
        rsp.keyValid    <= grantRw || grantRo;
        rsp.rwKey       <= grantRw;
        rsp.instanceId  <= (accept && isCreate) ? instanceCtr : 8'h00;
        rsp.diversifier <= (accept && isProdRw) ? diversify : 64'h0;
        rsp.data        <= (accept && req.cmd == SCFG_CMD_BUFRD) ? bufByte : 8'h00;
      end
      if (accept && isCreate) begin
        instanceCtr <= instanceCtr + 8'h01;
      end
      if (accept && req.cmd == SCFG_CMD_VERIFY) begin
        verifiedValid   <= 1'b1;
        verifiedProduct <= req.product;
      end
      if (grantRw) begin
        dirDirty <= 1'b1;
      end else if (accept && req.cmd == SCFG_CMD_DIRWR) begin
        dirDirty <= 1'b0;
      end
      if (doBegin) begin
        sessionState  <= SCFG_SESS_OPEN;
        verifiedValid <= 1'b0;
      end else if (doEnd) begin
        sessionState  <= SCFG_SESS_IDLE;
        verifiedValid <= 1'b0;
        dirDirty      <= 1'b0;
      end
    end
  end

  // ****************************************
  // General buffer, one byte per write request
  // ****************************************
  always_ff @(posedge mclk) begin
    if (accept && req.cmd == SCFG_CMD_BUFWR) begin
      buffer[req.offset] <= req.data;
    end
  end

  // Written-byte flags; end of session forgets every byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bufValid <= '0;
    end else if (doEnd) begin
      bufValid <= '0;
    end else if (accept && req.cmd == SCFG_CMD_BUFWR) begin
      bufValid[req.offset] <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_noUnprompted;
    @(posedge mclk) disable iff (!rst_n) rspValid |-> $past(reqValid);
  endproperty
  a_noUnprompted: assert property (p_noUnprompted) else $error("answer without command");

  property p_productNeedsSession;
    @(posedge mclk) disable iff (!rst_n)
      (reqValid && isProduct && sessionState != SCFG_SESS_OPEN) |=> (rsp.status == SCFG_ST_STATE);
  endproperty
  a_productNeedsSession: assert property (p_productNeedsSession) else $error("product cmd out of session");

  property p_rwNeedsVerify;
    @(posedge mclk) disable iff (!rst_n)
      (reqValid && isProdRw && !isCreate && !verifiedOk) |=> !rsp.keyValid && !rsp.sealValid;
  endproperty
  a_rwNeedsVerify: assert property (p_rwNeedsVerify) else $error("rw granted without verify");

  property p_denyNoSeal;
    @(posedge mclk) disable iff (!rst_n)
      (reqValid && isProdRw && !req.permit) |=> !rsp.sealValid && rsp.status != SCFG_ST_OK;
  endproperty
  a_denyNoSeal: assert property (p_denyNoSeal) else $error("seal without permission");

  property p_createLimit;
    @(posedge mclk) disable iff (!rst_n) (reqValid && isCreate && createReached) |=> !rsp.sealValid;
  endproperty
  a_createLimit: assert property (p_createLimit) else $error("create sealed past limit");

  property p_valueLimit;
    @(posedge mclk) disable iff (!rst_n) (reqValid && isValMod && valueReached) |=> !rsp.sealValid;
  endproperty
  a_valueLimit: assert property (p_valueLimit) else $error("value sealed past limit");

  property p_endCloses;
    @(posedge mclk) disable iff (!rst_n) doEnd |=> sessionState == SCFG_SESS_IDLE && !verifiedValid;
  endproperty
  a_endCloses: assert property (p_endCloses) else $error("end did not clear session");

  property p_sealState;
    @(posedge mclk) disable iff (!rst_n)
      (reqValid && req.cmd == SCFG_CMD_SEAL &&
       (sessionState == SCFG_SESS_IDLE || sessionState == SCFG_SESS_OPEN)) |=>
        rsp.sealValid && rsp.status == SCFG_ST_OK;
  endproperty
  a_sealState: assert property (p_sealState) else $error("transaction seal state wrong");

  property p_idleRefuse;
    @(posedge mclk) disable iff (!rst_n)
      (reqValid && !inSession && (isBuffer || req.cmd == SCFG_CMD_LIMRST)) |=> rsp.status == SCFG_ST_STATE;
  endproperty
  a_idleRefuse: assert property (p_idleRefuse) else $error("command accepted after end");

  property p_diversify;
    @(posedge mclk) disable iff (!rst_n) (rspValid && rsp.sealValid && rsp.rwKey) |->
      rsp.diversifier == $past(diversify);
  endproperty
  a_diversify: assert property (p_diversify) else $error("seal not diversified");
endmodule // scfg_flow_guard
`default_nettype wire

// ### tb/scfg_host_model.sv
// Purpose: Host application model that issues commands to the flow guard
// Assumes: Tasks are called at a falling edge of mclk
// Notes:   Idle request fields carry inverted data, never the last request
`timescale 1ns/1ns
`default_nettype none
module scfg_host_model (
  input  wire logic               mclk,
  output var logic                reqValid,
  output var scfg_pkg::scfg_req_s req
);
  import scfg_pkg::*;

  initial begin
    reqValid = 1'b0;
    req      = '0;
  end

  // Waits gap idle cycles, then holds one request across one taken edge
  task automatic issue(input scfg_req_s q, input int gap);
    if (gap > 0) begin
      reqValid = 1'b0;
      req      = scfg_req_s'(~q);
      repeat (gap) @(negedge mclk);
    end
    reqValid = 1'b1;
    req      = q;
    @(negedge mclk);
  endtask

  task automatic idle();
    reqValid = 1'b0;
    req      = scfg_req_s'(~req);
  endtask
endmodule // scfg_host_model
`default_nettype wire

// ### tb/secure_module_command_flow_guard_tb_top.sv
// Purpose: Self-checking bench comparing the flow guard with a reference model
// Assumes: Answers are sampled at the falling edge after the taken edge
// Notes:   Small limits shorten the count and value scenarios
`timescale 1ns/1ns
`default_nettype none
module secure_module_command_flow_guard_tb_top;
  import scfg_pkg::*;
  localparam logic [15:0] CLIM = 16'h0003;
  localparam logic [15:0] VLIM = 16'h0040;
  logic        mclk, rst_n, reqValid, rspValid, dirDirty;
  logic [31:0] mediaId, shellRef;
  logic [1:0]  sessionState;
  scfg_req_s   req, r;
  scfg_rsp_s   rsp;
  int          bad_count, checks_done, seed, sess, lastVer, createCnt, valUsed, instCnt, dirty;
  int          bufVal [1024];
  bit          bufOk [1024];

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  scfg_flow_guard #(.CREATE_LIM(CLIM), .VALUE_LIM(VLIM)) i_scfg_flow_guard (
    .mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .mediaId(mediaId),
    .shellRef(shellRef), .rspValid(rspValid), .rsp(rsp), .sessionState(sessionState),
    .dirDirty(dirDirty));
  scfg_host_model i_scfg_host_model (.mclk(mclk), .reqValid(reqValid), .req(req));

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic scfg_req_s mk(input int c, input int p, input int v);
    scfg_req_s q;
    q         = '0;
    q.cmd     = scfg_cmd_e'(4'(c));
    q.product = 8'(p);
    q.value   = 16'(v);
    q.length  = 8'h01;
    q.permit  = 1'b1;
    q.paramOk = 1'b1;
    return q;
  endfunction

  // ****************************************
  // Reference model and comparison per answer
  // ****************************************
  task automatic send(input scfg_req_s q, input int gap);
    logic [3:0] st;
    logic       ok, prod;
    int         c, off;
    c    = int'(q.cmd);
    off  = int'(q.offset);
    prod = c >= 3 && c <= 6;
    st   = SCFG_ST_OK;
    if (c == 0 || c == 15) st = SCFG_ST_BADCMD;
    else if (((c >= 2 && c <= 9) || (c >= 12 && c <= 14)) && sess != 3) st = SCFG_ST_STATE;
    else if (c >= 4 && c <= 6 && lastVer != int'(q.product)) st = SCFG_ST_NOVERIFY;
    else if ((prod || c == 7 || c == 14) && !(q.permit && q.paramOk)) st = SCFG_ST_DENIED;
    else if ((c == 3 && createCnt >= CLIM) || (c == 5 && valUsed >= VLIM)) st = SCFG_ST_LIMIT;
    else if ((c == 12 || c == 13) && (q.length == 0 || off + int'(q.length) > 1024)) st = SCFG_ST_RANGE;
    ok = st == SCFG_ST_OK;
    i_scfg_host_model.issue(q, gap);
    chk("rspValid", rspValid, 1);
    chk("status", rsp.status, st);
    chk("sealValid", rsp.sealValid, ok && (prod || c == 9 || c == 10));
    if (prod || c == 7) chk("keyValid", rsp.keyValid, ok);
    if (ok && (prod || c == 7)) chk("rwKey", rsp.rwKey, prod);
    if (ok && prod) chk("diversifier", rsp.diversifier, {mediaId, shellRef});
    if (ok && c == 3) chk("instanceId", rsp.instanceId, instCnt[7:0]);
    if (ok && c == 13) chk("data", rsp.data, bufOk[off] ? bufVal[off] : 0);
    if (ok) begin
      case (c)
        1: begin
          sess    = 3;
          lastVer = -1;
        end
        2: begin
          sess    = 2;
          lastVer = -1;
          dirty   = 0;
          bufOk   = '{default: 0};
        end
        3: begin
          instCnt++;
          createCnt++;
        end
        5: valUsed = (valUsed + q.value > 65535) ? 65535 : valUsed + q.value;
        8: lastVer = q.product;
        9: dirty = 0;
        12: begin
          bufVal[off] = q.data;
          bufOk[off]  = 1'b1;
        end
        14: begin
          createCnt = 0;
          valUsed   = 0;
        end
        default: ;
      endcase
      if (prod) dirty = 1;
    end
    chk("sessionState", sessionState, sess);
    chk("dirDirty", dirDirty, dirty);
  endtask

  initial begin
    #200000;
    bad_count++;
    test_done();
  end

  initial begin
    seed = 18221;
    {bad_count, checks_done, createCnt, valUsed, instCnt, dirty} = '0;
    sess     = 2;
    lastVer  = -1;
    bufOk    = '{default: 0};
    rst_n    = 1'b0;
    mediaId  = 32'h1234_5678;
    shellRef = 32'h9ABC_DEF0;
    repeat (20) @(negedge mclk);
    chk("rspValid", rspValid, 0);
    chk("sessionState", sessionState, 2);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("rspValid", rspValid, 0);
    $display("test reset done");
    for (int c = 0; c < 16; c++) if (c != 1) send(mk(c, 5, 0), 0);
    send(mk(1, 0, 0), 0);
    send(mk(6, 5, 0), 0);
    send(mk(8, 5, 0), 1);
    send(mk(4, 5, 0), 0);
    send(mk(5, 6, 1), 0);
    send(mk(7, 5, 0), 2);
    send(mk(9, 0, 0), 0);
    send(mk(10, 0, 0), 0);
    r = mk(3, 2, 0);
    r.permit = 1'b0;
    send(r, 0);
    $display("test walk done");
    for (int i = 0; i <= CLIM; i++) send(mk(3, i, 0), 0);
    send(mk(8, 1, 0), 0);
    for (int i = 0; i < 3; i++) send(mk(5, 1, 32), 0);
    r = mk(14, 0, 0);
    r.paramOk = 1'b0;
    send(r, 0);
    send(mk(3, 9, 0), 0);
    send(mk(14, 0, 0), 0);
    send(mk(3, 9, 0), 0);
    send(mk(5, 1, 1), 0);
    $display("test limits done");
    r = mk(12, 0, 0);
    r.offset = 10'h3FF;
    r.data = 8'hA5;
    send(r, 0);
    r.cmd = SCFG_CMD_BUFRD;
    send(r, 0);
    r.offset = 10'h3E8;
    r.length = 8'h19;
    send(r, 0);
    r.length = 8'h18;
    send(r, 0);
    r.length = 8'h00;
    send(r, 0);
    r.offset = 10'h000;
    r.length = 8'hFF;
    send(r, 0);
    $display("test buffer done");
    send(mk(2, 0, 0), 0);
    send(mk(4, 5, 0), 0);
    send(mk(1, 0, 0), 0);
    send(mk(4, 5, 0), 0);
    $display("test end done");
    for (int i = 0; i < 400; i++) begin
      r = mk($random(seed) & 15, $random(seed) & 3, $random(seed) & 15);
      if (r.cmd == SCFG_CMD_BEGIN && sess == 3) r.cmd = SCFG_CMD_SEARCH;
      r.permit  = ($random(seed) & 7) != 0;
      r.paramOk = ($random(seed) & 7) != 0;
      r.offset  = 10'($random(seed) & 15);
      r.length  = 8'($random(seed));
      r.data    = 8'($random(seed));
      if (i % 50 == 0) mediaId = $random(seed);
      send(r, $random(seed) & 1);
    end
    i_scfg_host_model.idle();
    @(negedge mclk);
    chk("rspValid", rspValid, 0);
    $display("test random done");
    test_done();
  end
endmodule // secure_module_command_flow_guard_tb_top
`default_nettype wire
